// file: src/cache_mode_defines.svh
// Constants for the cache mode control block
`ifndef CACHE_MODE_DEFINES_SVH
`define CACHE_MODE_DEFINES_SVH

// ****************************************
// Register map
// ****************************************
`define CM_ADDR_W 4
`define CM_OFS_CTL 4'h0
`define CM_OFS_STATUS 4'h4
`define CM_RESET_VAL 16'h0180
`define CM_WRITABLE 16'h1FED
`define CM_MASK_LSB 16

// ****************************************
// Field positions
// ****************************************
`define CM_B_L1_MISS 0
`define CM_B_WM_LO 2
`define CM_B_WM_HI 3
`define CM_B_DH_LO 5
`define CM_B_DH_HI 6
`define CM_B_SH_LO 7
`define CM_B_SH_HI 8
`define CM_B_FB_DIS 9
`define CM_B_L1_DIS 10
`define CM_B_INVAL 11

// ****************************************
// FIFO and addressing
// ****************************************
`define CM_FIFO_LVL_W 5
`define CM_FIFO_DEPTH 5'h10
`define CM_FIFO_HALF 5'h08
`define CM_ADDR_TILE_W 23

`endif

// file: src/cache_mode_pkg.sv
// Types for the cache mode control block
package cache_mode_pkg;
  typedef enum logic [1:0] {
    HASH_NONE = 2'h0,
    HASH_ONE = 2'h1,
    HASH_TWO = 2'h2,
    HASH_THREE = 2'h3
  } hash_sel_e;

  typedef enum logic [1:0] {
    WM_HALF = 2'h0,
    WM_FULL = 2'h1,
    WM_UNUSED = 2'h2,
    WM_NONE = 2'h3
  } wm_sel_e;

  // Write-back gate states, Gray along idle->burst->idle
  typedef enum logic [1:0] {
    WB_IDLE = 2'h0,
    WB_BURST = 2'h1
  } wb_state_e;
endpackage : cache_mode_pkg

// file: src/set_hash_unit.sv
// Registered XOR set-index hashing for sampler and data caches
`timescale 1ns/1ps
`default_nettype none
`include "cache_mode_defines.svh"
module set_hash_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] samp_sel,
  input wire logic [1:0] data_sel,
  input wire logic samp_hash_ok,
  input wire logic data_hash_ok,
  input wire logic [`CM_ADDR_TILE_W-1:0] samp_addr,
  input wire logic [3:0] samp_set,
  input wire logic [`CM_ADDR_TILE_W-1:0] data_addr,
  input wire logic [1:0] data_set,
  output logic [3:0] samp_set_out,
  output logic [1:0] data_set_out
);
  typedef struct packed {
    logic [3:0] samp;
    logic [1:0] data;
  } hash_s;
  hash_s cur_ff;
  hash_s nxt_cur;

  // Sampler mask from the selected scheme
  function automatic logic [3:0] samp_mask(input logic [1:0] sel,
                                           input logic [22:0] a);
    samp_mask = 4'h0;
    unique case (sel)
      2'h0: samp_mask = 4'h0;
      2'h1: samp_mask = a[16:13];
      2'h2: samp_mask = {a[17] ^ a[16], a[16] ^ a[15],
                         a[15] ^ a[14], a[14] ^ a[13]};
      2'h3: samp_mask = {a[22] ^ a[21] ^ a[20] ^ a[19],
                         a[18] ^ a[17] ^ a[16], a[15] ^ a[14], a[13]};
    endcase
  endfunction : samp_mask

  // Data cache mask, two bits only
  function automatic logic [1:0] data_mask(input logic [1:0] sel,
                                           input logic [22:0] a);
    data_mask = 2'h0;
    unique case (sel)
      2'h0: data_mask = 2'h0;
      2'h1: data_mask = a[14:13];
      2'h2: data_mask = {a[15] ^ a[14], a[14] ^ a[13]};
      2'h3: data_mask = {a[15] ^ a[14], a[13]};
    endcase
  endfunction : data_mask

  // One path serves fill and lookup alike
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.samp = samp_set ^
      (samp_hash_ok ? samp_mask(samp_sel, samp_addr) : 4'h0);
    nxt_cur.data = data_set ^
      (data_hash_ok ? data_mask(data_sel, data_addr) : 2'h0);
  end

  // Registered so outputs leave from flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign samp_set_out = cur_ff.samp;
  assign data_set_out = cur_ff.data;
endmodule : set_hash_unit
`default_nettype wire

// file: src/wb_watermark.sv
// Write-back FIFO watermark and burst gate for render caches
`timescale 1ns/1ps
`default_nettype none
`include "cache_mode_defines.svh"
module wb_watermark (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] wm_sel,
  input wire logic [`CM_FIFO_LVL_W-1:0] fifo_level,
  output logic wr_req
);
  typedef struct packed {
    cache_mode_pkg::wb_state_e st;
    logic req;
  } wb_s;
  wb_s cur_ff;
  wb_s nxt_cur;
  logic [`CM_FIFO_LVL_W-1:0] trip;
  logic [`CM_FIFO_LVL_W-1:0] stop;

  // Trip and stop levels per watermark setting
  always_comb begin
    trip = `CM_FIFO_HALF;
    stop = `CM_FIFO_LVL_W'(0);
    unique case (wm_sel)
      2'h0: trip = `CM_FIFO_HALF;
      2'h1: trip = `CM_FIFO_DEPTH;
      // Unused code acts as no watermark
      default: trip = `CM_FIFO_LVL_W'(1);
    endcase
  end

  // Burst runs from trip until the FIFO drains
  always_comb begin
    nxt_cur = cur_ff;
    unique case (cur_ff.st)
      cache_mode_pkg::WB_IDLE: begin
        if (fifo_level >= trip) begin
          nxt_cur.st = cache_mode_pkg::WB_BURST;
        end
      end
      cache_mode_pkg::WB_BURST: begin
        if (fifo_level == stop) begin
          nxt_cur.st = cache_mode_pkg::WB_IDLE;
        end
      end
      default: nxt_cur.st = cache_mode_pkg::WB_IDLE;
    endcase
    if (wm_sel == 2'h3) begin
      nxt_cur.req = (fifo_level != stop);
    end else begin
      nxt_cur.req = (nxt_cur.st == cache_mode_pkg::WB_BURST) &&
                    (fifo_level != stop);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '{st: cache_mode_pkg::WB_IDLE, req: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign wr_req = cur_ff.req;
endmodule : wb_watermark
`default_nettype wire

// file: src/cache_mode_set_hash_ctl.sv
// Cache mode register with invalidate, disables, hashing and watermark
`timescale 1ns/1ps
`default_nettype none
`include "cache_mode_defines.svh"
module cache_mode_set_hash_ctl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`CM_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic samp_16way,
  input wire logic samp_imm,
  input wire logic [`CM_ADDR_TILE_W-1:0] samp_addr,
  input wire logic [3:0] samp_set,
  output logic [3:0] samp_set_hashed,
  input wire logic data_16way,
  input wire logic data_imm,
  input wire logic [`CM_ADDR_TILE_W-1:0] data_addr,
  input wire logic [1:0] data_set,
  output logic [1:0] data_set_hashed,
  input wire logic [`CM_FIFO_LVL_W-1:0] depth_render_cache_level,
  output logic depth_render_cache_wr_req,
  input wire logic [`CM_FIFO_LVL_W-1:0] color_render_cache_level,
  output logic color_render_cache_wr_req,
  output logic inval_caches,
  output logic l1_inst_bypass,
  output logic l1_inst_unique_fwd,
  output logic l2_fill_buf_dis
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] ctl;
    logic ack;
    logic [31:0] rdata;
    logic inval;
    logic l1_bypass;
    logic l1_unique;
    logic fb_dis;
  } ctl_s;
  ctl_s cur_ff;
  ctl_s nxt_cur;
  logic req;

  // Masked update of a 16-bit field
  function automatic logic [15:0] mask_merge(input logic [15:0] old,
                                             input logic [31:0] wd);
    logic [15:0] m;
    m = wd[31:`CM_MASK_LSB] & `CM_WRITABLE;
    mask_merge = (old & ~m) | (wd[15:0] & m);
  endfunction : mask_merge

  assign req = (avs_read || avs_write) && !cur_ff.ack;

  // ****************************************
  // Bus slave and control decode
  // ****************************************
  // One wait cycle, then ack; ack blocks a repeat take
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.ack = req;
    if (req && avs_write && avs_address == `CM_OFS_CTL) begin
      nxt_cur.ctl = mask_merge(cur_ff.ctl, avs_writedata);
    end
    if (req && avs_read) begin
      nxt_cur.rdata = 32'h0;
      unique case (avs_address)
        `CM_OFS_CTL: nxt_cur.rdata = {16'h0, cur_ff.ctl};
        `CM_OFS_STATUS: nxt_cur.rdata = {28'h0, cur_ff.fb_dis,
          cur_ff.l1_unique, cur_ff.l1_bypass, cur_ff.inval};
        default: nxt_cur.rdata = 32'h0;
      endcase
    end
    nxt_cur.inval = nxt_cur.ctl[`CM_B_INVAL];
    nxt_cur.l1_bypass = nxt_cur.ctl[`CM_B_L1_DIS];
    nxt_cur.l1_unique = nxt_cur.ctl[`CM_B_L1_MISS] &&
                        !nxt_cur.ctl[`CM_B_L1_DIS];
    nxt_cur.fb_dis = nxt_cur.ctl[`CM_B_FB_DIS];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_ff <= '{ctl: `CM_RESET_VAL, ack: 1'b0, rdata: 32'h0,
                  inval: 1'b0, l1_bypass: 1'b0, l1_unique: 1'b0,
                  fb_dis: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign avs_waitrequest = !cur_ff.ack;
  assign avs_readdata = cur_ff.rdata;
  assign inval_caches = cur_ff.inval;
  assign l1_inst_bypass = cur_ff.l1_bypass;
  assign l1_inst_unique_fwd = cur_ff.l1_unique;
  assign l2_fill_buf_dis = cur_ff.fb_dis;

  // ****************************************
  // Hashing and write-back gates
  // ****************************************
  set_hash_unit u_hash (
    .clk(clk),
    .rst_n(rst_n),
    .samp_sel(cur_ff.ctl[`CM_B_SH_HI:`CM_B_SH_LO]),
    .data_sel(cur_ff.ctl[`CM_B_DH_HI:`CM_B_DH_LO]),
    .samp_hash_ok(samp_16way && !samp_imm),
    .data_hash_ok(data_16way && !data_imm),
    .samp_addr(samp_addr),
    .samp_set(samp_set),
    .data_addr(data_addr),
    .data_set(data_set),
    .samp_set_out(samp_set_hashed),
    .data_set_out(data_set_hashed)
  );

  // Depth and colour caches share the setting
  wb_watermark u_wb_depth (
    .clk(clk),
    .rst_n(rst_n),
    .wm_sel(cur_ff.ctl[`CM_B_WM_HI:`CM_B_WM_LO]),
    .fifo_level(depth_render_cache_level),
    .wr_req(depth_render_cache_wr_req)
  );

  wb_watermark u_wb_color (
    .clk(clk),
    .rst_n(rst_n),
    .wm_sel(cur_ff.ctl[`CM_B_WM_HI:`CM_B_WM_LO]),
    .fifo_level(color_render_cache_level),
    .wr_req(color_render_cache_wr_req)
  );

  // ****************************************
  // Checks
  // ****************************************
  sequence s_take_write;
    avs_write && !avs_waitrequest && avs_address == `CM_OFS_CTL;
  endsequence

  property p_inval_level;
    @(posedge clk) disable iff (!rst_n)
      inval_caches == cur_ff.ctl[`CM_B_INVAL];
  endproperty
  a_inval_level: assert property (p_inval_level)
    else $error("invalidate does not follow bit");

  property p_inval_hold;
    @(posedge clk) disable iff (!rst_n)
      inval_caches && !(avs_write && !cur_ff.ack) |=> inval_caches;
  endproperty
  a_inval_hold: assert property (p_inval_hold)
    else $error("invalidate dropped without write");

  property p_bypass_wins;
    @(posedge clk) disable iff (!rst_n)
      !(l1_inst_bypass && l1_inst_unique_fwd);
  endproperty
  a_bypass_wins: assert property (p_bypass_wins)
    else $error("bit 10 did not override bit 0");

  property p_fill_dis;
    @(posedge clk) disable iff (!rst_n)
      l2_fill_buf_dis == cur_ff.ctl[`CM_B_FB_DIS];
  endproperty
  a_fill_dis: assert property (p_fill_dis)
    else $error("fill buffer disable wrong");

  property p_samp_gate;
    @(posedge clk) disable iff (!rst_n)
      !(samp_16way && !samp_imm) |=> samp_set_hashed == $past(samp_set);
  endproperty
  a_samp_gate: assert property (p_samp_gate)
    else $error("sampler hashed outside 16-way");

  property p_data_gate;
    @(posedge clk) disable iff (!rst_n)
      data_imm |=> data_set_hashed == $past(data_set);
  endproperty
  a_data_gate: assert property (p_data_gate)
    else $error("data hashed for immediate data");

  property p_mask_write;
    @(posedge clk) disable iff (!rst_n)
      s_take_write |=> cur_ff.ctl == $past(mask_merge(cur_ff.ctl,
                                                      avs_writedata));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("masked write wrong");

  property p_mask_read;
    @(posedge clk) disable iff (!rst_n)
      avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0;
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask half not zero");

  property p_unique;
    @(posedge clk) disable iff (!rst_n)
      l1_inst_unique_fwd |-> cur_ff.ctl[`CM_B_L1_MISS];
  endproperty
  a_unique: assert property (p_unique)
    else $error("unique forward without bit 0");

  property p_wm_none;
    @(posedge clk) disable iff (!rst_n)
      cur_ff.ctl[`CM_B_WM_HI:`CM_B_WM_LO] == 2'h3 &&
      $stable(cur_ff.ctl) && depth_render_cache_level != 5'h00
      |=> depth_render_cache_wr_req;
  endproperty
  a_wm_none: assert property (p_wm_none)
    else $error("no request with valid entry");

  // ****************************************
  // Bus handshake, hashing and burst checks
  // ****************************************
  // Control read answered with the stored word
  sequence s_take_read;
    avs_read && !avs_waitrequest && avs_address == `CM_OFS_CTL;
  endsequence

  property p_ack_one;
    @(posedge clk) disable iff (!rst_n)
      !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("waitrequest low for more than one cycle");

  property p_answer;
    @(posedge clk) disable iff (!rst_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered after one wait");

  property p_ctl_read;
    @(posedge clk) disable iff (!rst_n)
      s_take_read |-> avs_readdata == {16'h0, cur_ff.ctl};
  endproperty
  a_ctl_read: assert property (p_ctl_read)
    else $error("control read data wrong");

  // Sampler schemes worked out from the address bits
  property p_samp_one;
    @(posedge clk) disable iff (!rst_n)
      samp_16way && !samp_imm && cur_ff.ctl[`CM_B_SH_HI:`CM_B_SH_LO] == 2'h1
      |=> samp_set_hashed == $past(samp_set ^ samp_addr[16:13]);
  endproperty
  a_samp_one: assert property (p_samp_one)
    else $error("sampler scheme one wrong");

  property p_samp_two;
    @(posedge clk) disable iff (!rst_n)
      samp_16way && !samp_imm && cur_ff.ctl[`CM_B_SH_HI:`CM_B_SH_LO] == 2'h2
      |=> samp_set_hashed ==
        $past(samp_set ^ samp_addr[17:14] ^ samp_addr[16:13]);
  endproperty
  a_samp_two: assert property (p_samp_two)
    else $error("sampler scheme two wrong");

  property p_samp_three;
    @(posedge clk) disable iff (!rst_n)
      samp_16way && !samp_imm && cur_ff.ctl[`CM_B_SH_HI:`CM_B_SH_LO] == 2'h3
      |=> samp_set_hashed == $past(samp_set ^ {^samp_addr[22:19],
        ^samp_addr[18:16], ^samp_addr[15:14], samp_addr[13]});
  endproperty
  a_samp_three: assert property (p_samp_three)
    else $error("sampler scheme three wrong");

  // Data cache schemes on the two low set bits
  property p_data_one;
    @(posedge clk) disable iff (!rst_n)
      data_16way && !data_imm && cur_ff.ctl[`CM_B_DH_HI:`CM_B_DH_LO] == 2'h1
      |=> data_set_hashed == $past(data_set ^ data_addr[14:13]);
  endproperty
  a_data_one: assert property (p_data_one)
    else $error("data scheme one wrong");

  property p_data_two;
    @(posedge clk) disable iff (!rst_n)
      data_16way && !data_imm && cur_ff.ctl[`CM_B_DH_HI:`CM_B_DH_LO] == 2'h2
      |=> data_set_hashed ==
        $past(data_set ^ data_addr[15:14] ^ data_addr[14:13]);
  endproperty
  a_data_two: assert property (p_data_two)
    else $error("data scheme two wrong");

  // Below the mark an idle gate stays idle
  property p_wm_half;
    @(posedge clk) disable iff (!rst_n)
      cur_ff.ctl[`CM_B_WM_HI:`CM_B_WM_LO] == 2'h0 && $stable(cur_ff.ctl) &&
      !depth_render_cache_wr_req &&
      depth_render_cache_level < `CM_FIFO_HALF
      |=> !depth_render_cache_wr_req;
  endproperty
  a_wm_half: assert property (p_wm_half)
    else $error("request before half full");

  property p_wm_full;
    @(posedge clk) disable iff (!rst_n)
      cur_ff.ctl[`CM_B_WM_HI:`CM_B_WM_LO] == 2'h1 && $stable(cur_ff.ctl) &&
      !depth_render_cache_wr_req &&
      depth_render_cache_level < `CM_FIFO_DEPTH
      |=> !depth_render_cache_wr_req;
  endproperty
  a_wm_full: assert property (p_wm_full)
    else $error("request before full");

  // A started burst runs until the FIFO is empty
  property p_wm_drain;
    @(posedge clk) disable iff (!rst_n)
      $stable(cur_ff.ctl) && depth_render_cache_wr_req &&
      depth_render_cache_level != 5'h00 |=> depth_render_cache_wr_req;
  endproperty
  a_wm_drain: assert property (p_wm_drain)
    else $error("burst stopped before drain");

  property p_wm_empty;
    @(posedge clk) disable iff (!rst_n)
      depth_render_cache_level == 5'h00 |=> !depth_render_cache_wr_req;
  endproperty
  a_wm_empty: assert property (p_wm_empty)
    else $error("request with empty FIFO");
endmodule : cache_mode_set_hash_ctl
`default_nettype wire

// file: bench/cache_fifo_model.sv
// Render cache write-back FIFO occupancy model for the far side
`timescale 1ns/1ps
`default_nettype none
`include "cache_mode_defines.svh"
module cache_fifo_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic wr_req,
  output logic [`CM_FIFO_LVL_W-1:0] level
);
  // ****************************************
  // Occupancy counter
  // ****************************************
  // One entry in per push, one out per granted request; stops at bounds
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level <= 5'h00;
    end else begin
      level <= level + 5'((push && level != `CM_FIFO_DEPTH) ? 1 : 0)
        - 5'((wr_req && level != 5'h00) ? 1 : 0);
    end
  end
endmodule : cache_fifo_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the cache mode control block
`timescale 1ns/1ps
`default_nettype none
`include "cache_mode_defines.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic samp_16way = 1'b1;
  logic samp_imm = 1'b0;
  logic data_16way = 1'b1;
  logic data_imm = 1'b0;
  logic [22:0] addr = 23'h5AAE35;
  logic [3:0] samp_set = 4'hA;
  logic [1:0] data_set = 2'h1;
  logic [3:0] samp_hashed;
  logic [1:0] data_hashed;
  logic push = 1'b0;
  logic [4:0] level;
  logic dr_req;
  logic cr_req;
  logic inval_caches;
  logic l1_inst_bypass;
  logic l1_inst_unique_fwd;
  logic l2_fill_buf_dis;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] rd;

  always #4 clk = ~clk;

  cache_mode_set_hash_ctl u_cache_mode_set_hash_ctl (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .samp_16way(samp_16way),
    .samp_imm(samp_imm), .samp_addr(addr), .samp_set(samp_set),
    .samp_set_hashed(samp_hashed), .data_16way(data_16way),
    .data_imm(data_imm), .data_addr(addr), .data_set(data_set),
    .data_set_hashed(data_hashed), .depth_render_cache_level(level),
    .depth_render_cache_wr_req(dr_req),
    .color_render_cache_level(level),
    .color_render_cache_wr_req(cr_req), .inval_caches(inval_caches),
    .l1_inst_bypass(l1_inst_bypass),
    .l1_inst_unique_fwd(l1_inst_unique_fwd),
    .l2_fill_buf_dis(l2_fill_buf_dis)
  );

  cache_fifo_model u_cache_fifo_model (
    .clk(clk), .rst_n(rst_n), .push(push), .wr_req(dr_req), .level(level)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge clk);
  endtask : bus

  function automatic logic [3:0] s_exp(logic [1:0] c);
    case (c)
      2'h0: return samp_set;
      2'h1: return samp_set ^ addr[16:13];
      2'h2: return samp_set ^ (addr[17:14] ^ addr[16:13]);
      default: return samp_set ^ {^addr[22:19], ^addr[18:16],
                                  addr[15] ^ addr[14], addr[13]};
    endcase
  endfunction : s_exp

  function automatic logic [1:0] d_exp(logic [1:0] c);
    case (c)
      2'h0: return data_set;
      2'h1: return data_set ^ addr[14:13];
      2'h2: return data_set ^ (addr[15:14] ^ addr[14:13]);
      default: return data_set ^ {addr[15] ^ addr[14], addr[13]};
    endcase
  endfunction : d_exp

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_and_mask();
    bus(1'b0, 4'h0, 32'h0);
    chk("ctl reset", 32'h00000180, rd);
    bus(1'b1, 4'h0, 32'h0000FFFF);
    bus(1'b0, 4'h0, 32'h0);
    chk("unmasked write", 32'h00000180, rd);
    bus(1'b0, 4'h8, 32'h0);
    chk("unmapped read", 32'h0, rd);
  endtask : t_reset_and_mask

  task automatic t_invalidate();
    // Engine idle here: no traffic precedes the invalidate
    bus(1'b1, 4'h0, 32'h08000800);
    repeat (20) @(negedge clk);
    chk("inval level", 32'h1, 32'(inval_caches));
    bus(1'b0, 4'h4, 32'h0);
    chk("status inval", 32'h1, rd & 32'h1);
    // Cleared again before any resume
    bus(1'b1, 4'h0, 32'h08000000);
    chk("inval clear", 32'h0, 32'(inval_caches));
  endtask : t_invalidate

  task automatic t_disables();
    bus(1'b1, 4'h0, 32'h06010201);
    chk("unique fwd", 32'h1, 32'(l1_inst_unique_fwd));
    chk("fill dis", 32'h1, 32'(l2_fill_buf_dis));
    bus(1'b1, 4'h0, 32'h04000400);
    chk("bypass", 32'h1, 32'(l1_inst_bypass));
    chk("bypass wins", 32'h0, 32'(l1_inst_unique_fwd));
    bus(1'b1, 4'h0, 32'h06010000);
    chk("fill on", 32'h0, 32'(l2_fill_buf_dis));
  endtask : t_disables

  task automatic t_hash();
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 4'h0, {16'h01E0, 7'h0, 2'(c), 2'(c), 5'h0});
      repeat (2) @(negedge clk);
      chk("samp hash", 32'(s_exp(2'(c))), 32'(samp_hashed));
      chk("data hash", 32'(d_exp(2'(c))), 32'(data_hashed));
    end
    @(posedge clk);
    samp_16way <= 1'b0;
    data_imm <= 1'b1;
    repeat (2) @(negedge clk);
    chk("samp plain", 32'(samp_set), 32'(samp_hashed));
    chk("data plain", 32'(data_set), 32'(data_hashed));
    // Immediate sampler data and a data cache not in 16-way stay unhashed
    @(posedge clk);
    samp_16way <= 1'b1;
    samp_imm <= 1'b1;
    data_16way <= 1'b0;
    data_imm <= 1'b0;
    repeat (2) @(negedge clk);
    chk("samp imm", 32'(samp_set), 32'(samp_hashed));
    chk("data not 16way", 32'(data_set), 32'(data_hashed));
  endtask : t_hash

  // Fills below the threshold, then to it, and counts the drained burst
  task automatic t_wm(input logic [1:0] code, input int thr);
    int n;
    bus(1'b1, 4'h0, {16'h000C, 12'h0, code, 2'h0});
    // One push short of the mark; nothing when the mark is one entry
    if (thr > 1) begin
      @(posedge clk);
      push <= 1'b1;
      repeat (thr - 1) @(posedge clk);
      push <= 1'b0;
    end
    repeat (3) @(negedge clk);
    chk("below mark", 32'h0, 32'(dr_req));
    @(posedge clk);
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    n = 0;
    repeat (40) @(posedge clk) n += (dr_req === 1'b1 && level != 0);
    chk("burst size", 32'(thr), 32'(n));
    chk("drained", 32'h0, 32'(level));
    chk("req idle", 32'h0, 32'(dr_req));
    chk("color req", 32'h0, 32'(cr_req));
  endtask : t_wm

  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_and_mask();
    t_invalidate();
    t_disables();
    t_hash();
    t_wm(2'h0, 8);
    t_wm(2'h1, 16);
    t_wm(2'h3, 1);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
